// ==== hw/flash_self_prog.sv ====
`timescale 1ns/1ps
`include "flash_prog_map.svh"

module flash_self_prog #(
    parameter logic [18:0] ERASE_CYC = 19'(`ERASE_CYCLES),
    parameter logic [18:0] PROG_CYC = 19'(`PROG_CYCLES)
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic write_abort_pin,
    output logic cpu_stall,
    output flash_prog_pkg::arr_rd_t arr_rd,
    input wire logic [15:0] arr_rdata,
    output flash_prog_pkg::arr_cmd_t arr_cmd
);
    import flash_prog_pkg::*;

    // ----------
    // Helpers
    // ----------
    // Only the low 21 bits move; bit 21 keeps the space select
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
        logic [20:0] low;
        low = up ? (p[20:0] + 21'h000001) : (p[20:0] - 21'h000001);
        return {p[21], low};
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                              input logic [7:0] val,
                                              input logic en);
        return en ? val : old;
    endfunction

    // ----------
    // State
    // ----------
    seq_state_t state_r, state_nxt;
    unlock_t unlock_r, unlock_nxt;
    ctl_t ctl_r, ctl_nxt;
    logic [21:0] table_pointer_r, table_pointer_nxt;
    logic [7:0] table_byte_latch_r, table_byte_latch_nxt;
    logic write_done_irq_flag_r, write_done_irq_flag_nxt;
    logic [7:0] hold_r [`HOLD_COUNT];
    logic [7:0] hold_nxt [`HOLD_COUNT];
    logic [1:0] rd_mode_r, rd_mode_nxt;
    logic byte_sel_r, byte_sel_nxt;
    logic rd_ack_r, rd_ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    arr_rd_t arr_rd_r, arr_rd_nxt;
    arr_cmd_t arr_cmd_r, arr_cmd_nxt;
    logic abort_meta_r, abort_sync_r;
    logic tmr_start;
    logic tmr_abort;
    logic [18:0] tmr_load;
    logic tmr_done;

    logic busy;
    logic wr_take;
    logic rd_take;
    logic [63:0] hold_flat;

    // ----------
    // Bus handshake
    // ----------
    // The bus stalls during a long write: this is how the core is held
    assign busy = (state_r != ST_IDLE);
    assign wr_take = avs_write && !busy;
    assign rd_take = avs_read && !busy && rd_ack_r;
    assign avs_waitrequest = busy || (avs_read && !rd_ack_r);
    assign avs_readdata = rdata_r;
    assign cpu_stall = (state_r == ST_LONG);
    assign arr_rd = arr_rd_r;
    assign arr_cmd = arr_cmd_r;

    always_comb begin
        for (int i = 0; i < `HOLD_COUNT; i++) begin
            hold_flat[i*8 +: 8] = hold_r[i];
        end
    end

    // ----------
    // Abort pin synchroniser
    // ----------
    // Pin is asynchronous; only the second flop is read
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            abort_meta_r <= 1'b0;
            abort_sync_r <= 1'b0;
        end else begin
            abort_meta_r <= write_abort_pin;
            abort_sync_r <= abort_meta_r;
        end
    end

    // ----------
    // Sequencer next state
    // ----------
    // Reads answer one cycle late so read data comes from a flop
    always_comb begin
        logic [21:0] eff_ptr;
        logic [7:0] wd;
        logic [1:0] mode;
        logic start_ok;
        eff_ptr = table_pointer_r;
        wd = avs_writedata[7:0];
        mode = avs_writedata[`CMD_MODE_HI:`CMD_MODE_LO];
        start_ok = 1'b0;
        state_nxt = state_r;
        unlock_nxt = unlock_r;
        ctl_nxt = ctl_r;
        table_pointer_nxt = table_pointer_r;
        table_byte_latch_nxt = table_byte_latch_r;
        write_done_irq_flag_nxt = write_done_irq_flag_r;
        hold_nxt = hold_r;
        rd_mode_nxt = rd_mode_r;
        byte_sel_nxt = byte_sel_r;
        rd_ack_nxt = 1'b0;
        rdata_nxt = rdata_r;
        arr_rd_nxt = arr_rd_r;
        arr_cmd_nxt = arr_cmd_r;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        tmr_load = PROG_CYC;

        // Register reads
        if (avs_read && !busy && !rd_ack_r) begin
            rd_ack_nxt = 1'b1;
            case (avs_address)
                `OFS_CONTROL: rdata_nxt = {24'h000000, ctl_r.pgm_sel, ctl_r.cfg_sel, 1'b0,
                                           ctl_r.row_erase, ctl_r.wr_err, ctl_r.wr_en,
                                           ctl_r.wr_start, 1'b0};
                `OFS_LATCH: rdata_nxt = {24'h000000, table_byte_latch_r};
                `OFS_POINTER: rdata_nxt = {10'h000, table_pointer_r};
                `OFS_FLAGS: rdata_nxt = {27'h0000000, write_done_irq_flag_r, 4'h0};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        if (rd_take) begin
            unlock_nxt = UL_IDLE;
        end

        // Register writes
        if (wr_take) begin
            unlock_nxt = UL_IDLE;
            case (avs_address)
                `OFS_CONTROL: begin
                    if (avs_byteenable[0]) begin
                        ctl_nxt.pgm_sel = wd[`CTL_PGM_SEL];
                        ctl_nxt.cfg_sel = wd[`CTL_CFG_SEL];
                        ctl_nxt.row_erase = wd[`CTL_ROW_ERASE];
                        ctl_nxt.wr_err = wd[`CTL_WR_ERR];
                        ctl_nxt.wr_en = wd[`CTL_WR_EN];
                        if (wd[`CTL_WR_START]) begin
                            // Program space only, enabled, unlocked just before
                            start_ok = (unlock_r == UL_ARMED) && wd[`CTL_WR_EN]
                                       && wd[`CTL_PGM_SEL] && !wd[`CTL_CFG_SEL];
                            ctl_nxt.wr_err = 1'b1;
                        end
                    end
                end
                `OFS_UNLOCK: begin
                    if (avs_byteenable[0]) begin
                        if (wd == `UNLOCK_KEY1) begin
                            unlock_nxt = UL_HALF;
                        end else if (wd == `UNLOCK_KEY2 && unlock_r == UL_HALF) begin
                            unlock_nxt = UL_ARMED;
                        end
                    end
                end
                `OFS_LATCH: begin
                    table_byte_latch_nxt = merge_byte(table_byte_latch_r, wd,
                                                      avs_byteenable[0]);
                end
                `OFS_POINTER: begin
                    table_pointer_nxt[7:0] = merge_byte(table_pointer_r[7:0], wd,
                                                        avs_byteenable[0]);
                    table_pointer_nxt[15:8] = merge_byte(table_pointer_r[15:8],
                                                         avs_writedata[15:8],
                                                         avs_byteenable[1]);
                    if (avs_byteenable[2]) begin
                        table_pointer_nxt[21:16] = avs_writedata[21:16];
                    end
                end
                `OFS_FLAGS: begin
                    // Software clears by writing zero; a new event wins below
                    if (avs_byteenable[0] && !wd[`FLG_WR_DONE]) begin
                        write_done_irq_flag_nxt = 1'b0;
                    end
                end
                `OFS_TABLE_CMD: begin
                    if (avs_byteenable[0]) begin
                        if (mode == `MODE_PRE_INC) begin
                            eff_ptr = ptr_step(table_pointer_r, 1'b1);
                        end
                        if (wd[`CMD_READ]) begin
                            arr_rd_nxt.rd_en = 1'b1;
                            arr_rd_nxt.word_addr = eff_ptr[20:1];
                            byte_sel_nxt = eff_ptr[0];
                            rd_mode_nxt = mode;
                            table_pointer_nxt = eff_ptr;
                            state_nxt = ST_RD_ISSUE;
                        end else if (wd[`CMD_WRITE]) begin
                            // Only the staging byte moves, never the array
                            hold_nxt[eff_ptr[2:0]] = table_byte_latch_r;
                            if (mode == `MODE_POST_INC) begin
                                table_pointer_nxt = ptr_step(eff_ptr, 1'b1);
                            end else if (mode == `MODE_POST_DEC) begin
                                table_pointer_nxt = ptr_step(eff_ptr, 1'b0);
                            end else begin
                                table_pointer_nxt = eff_ptr;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Long write launch
        if (start_ok) begin
            ctl_nxt.wr_start = 1'b1;
            state_nxt = ST_LONG;
            tmr_start = 1'b1;
            if (wd[`CTL_ROW_ERASE]) begin
                arr_cmd_nxt.erase = 1'b1;
                arr_cmd_nxt.row = table_pointer_r[21:6];
                tmr_load = ERASE_CYC;
            end else begin
                arr_cmd_nxt.prog = 1'b1;
                arr_cmd_nxt.block = table_pointer_r[21:3];
                arr_cmd_nxt.data = hold_flat;
            end
        end

        // Sequencer
        case (state_r)
            ST_IDLE: begin
            end
            ST_RD_ISSUE: begin
                arr_rd_nxt.rd_en = 1'b0;
                state_nxt = ST_RD_CAPTURE;
            end
            ST_RD_CAPTURE: begin
                table_byte_latch_nxt = byte_sel_r ? arr_rdata[15:8] : arr_rdata[7:0];
                if (rd_mode_r == `MODE_POST_INC) begin
                    table_pointer_nxt = ptr_step(table_pointer_r, 1'b1);
                end else if (rd_mode_r == `MODE_POST_DEC) begin
                    table_pointer_nxt = ptr_step(table_pointer_r, 1'b0);
                end
                state_nxt = ST_IDLE;
            end
            ST_LONG: begin
                if (abort_sync_r) begin
                    // Error flag stays set so software can spot the torn write
                    tmr_abort = 1'b1;
                    ctl_nxt.wr_start = 1'b0;
                    arr_cmd_nxt.erase = 1'b0;
                    arr_cmd_nxt.prog = 1'b0;
                    for (int i = 0; i < `HOLD_COUNT; i++) begin
                        hold_nxt[i] = `HOLD_RESET;
                    end
                    state_nxt = ST_IDLE;
                end else if (tmr_done) begin
                    ctl_nxt.wr_start = 1'b0;
                    ctl_nxt.wr_err = 1'b0;
                    ctl_nxt.row_erase = 1'b0;
                    arr_cmd_nxt.erase = 1'b0;
                    arr_cmd_nxt.prog = 1'b0;
                    write_done_irq_flag_nxt = 1'b1;
                    for (int i = 0; i < `HOLD_COUNT; i++) begin
                        hold_nxt[i] = `HOLD_RESET;
                    end
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------
    // Sequencer registers
    // ----------
    // Holding bytes idle at FFh so unloaded bytes program nothing
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            unlock_r <= UL_IDLE;
            ctl_r <= '0;
            table_pointer_r <= 22'h000000;
            table_byte_latch_r <= 8'h00;
            write_done_irq_flag_r <= 1'b0;
            for (int i = 0; i < `HOLD_COUNT; i++) begin
                hold_r[i] <= `HOLD_RESET;
            end
            rd_mode_r <= `MODE_KEEP;
            byte_sel_r <= 1'b0;
            rd_ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
            arr_rd_r <= '0;
            arr_cmd_r <= '0;
        end else begin
            state_r <= state_nxt;
            unlock_r <= unlock_nxt;
            ctl_r <= ctl_nxt;
            table_pointer_r <= table_pointer_nxt;
            table_byte_latch_r <= table_byte_latch_nxt;
            write_done_irq_flag_r <= write_done_irq_flag_nxt;
            hold_r <= hold_nxt;
            rd_mode_r <= rd_mode_nxt;
            byte_sel_r <= byte_sel_nxt;
            rd_ack_r <= rd_ack_nxt;
            rdata_r <= rdata_nxt;
            arr_rd_r <= arr_rd_nxt;
            arr_cmd_r <= arr_cmd_nxt;
        end
    end

    // ----------
    // Programming timer
    // ----------
    // Duration is ours alone; the array gives no done signal
    long_write_timer u_timer (
        .mclk(mclk),
        .resetn(resetn),
        .start(tmr_start),
        .abort(tmr_abort),
        .load(tmr_load),
        .done(tmr_done)
    );
endmodule // flash_self_prog

// ==== hw/flash_prog_map.svh ====
// Operation
// - Table read fetches one byte into latch
// - Table read may step pointer afterwards
// - Pointer bit zero picks high or low byte
// - Erase always clears one 64-byte row
// - No single-word erase exists
// - Erase row from pointer bits 21:6
// - Long write blocked while write enable clear
// - Row-erase bit selects erase on next start
// - Start only after 55h then 0AAh unlock
// - Write-start after unlock begins the cycle
// - Core stalled during long write
// - Internal timer ends every long write that the abort pin does not cut short
// - Row erase stalls about 2 ms
// - Programming works on 8-byte blocks only
// - Eight byte-wide holding registers
// - Table write touches holding register only
// - Holding registers reset to FFh after writes
// - FFh byte leaves flash byte unchanged
// - Write-start set by software, cleared by hardware
// - Completion sets write-done flag bit 4
// - Error flag on abort or bad start
// - Pointer bits 2:0 pick holding register
`ifndef FLASH_PROG_MAP_SVH
`define FLASH_PROG_MAP_SVH

// ----------
// Register byte offsets
// ----------
`define OFS_CONTROL 5'h00
`define OFS_UNLOCK 5'h04
`define OFS_LATCH 5'h08
`define OFS_POINTER 5'h0C
`define OFS_FLAGS 5'h10
`define OFS_TABLE_CMD 5'h14

// ----------
// Field positions
// ----------
`define CTL_PGM_SEL 7
`define CTL_CFG_SEL 6
`define CTL_ROW_ERASE 4
`define CTL_WR_ERR 3
`define CTL_WR_EN 2
`define CTL_WR_START 1
`define FLG_WR_DONE 4
`define CMD_READ 0
`define CMD_WRITE 1
`define CMD_MODE_LO 2
`define CMD_MODE_HI 3

// ----------
// Values
// ----------
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
`define HOLD_RESET 8'hFF
`define HOLD_COUNT 8
`define MODE_KEEP 2'h0
`define MODE_POST_INC 2'h1
`define MODE_POST_DEC 2'h2
`define MODE_PRE_INC 2'h3

// ----------
// Timing
// ----------
`define MCLK_MHZ 200
`define ERASE_TIME_US 2000
`define PROG_TIME_US 2000
`define ERASE_CYCLES (`ERASE_TIME_US * `MCLK_MHZ)
`define PROG_CYCLES (`PROG_TIME_US * `MCLK_MHZ)

`endif

// ==== hw/flash_prog_pkg.sv ====
package flash_prog_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_ISSUE,
        ST_RD_CAPTURE,
        ST_LONG
    } seq_state_t;

    typedef enum logic [1:0] {
        UL_IDLE,
        UL_HALF,
        UL_ARMED
    } unlock_t;

    typedef struct packed {
        logic pgm_sel;
        logic cfg_sel;
        logic row_erase;
        logic wr_err;
        logic wr_en;
        logic wr_start;
    } ctl_t;

    typedef struct packed {
        logic erase;
        logic prog;
        logic [15:0] row;
        logic [18:0] block;
        logic [63:0] data;
    } arr_cmd_t;

    typedef struct packed {
        logic rd_en;
        logic [19:0] word_addr;
    } arr_rd_t;

endpackage

// ==== hw/long_write_timer.sv ====
`timescale 1ns/1ps
`include "flash_prog_map.svh"

module long_write_timer (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire logic abort,
    input wire logic [18:0] load,
    output logic done
);
    logic [18:0] cnt_r;
    logic [18:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (abort) begin
            run_nxt = 1'b0;
            cnt_nxt = 19'h00000;
        end else if (start) begin
            run_nxt = 1'b1;
            cnt_nxt = load;
        end else if (run_r) begin
            if (cnt_r <= 19'h00001) begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 19'h00001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_r <= 19'h00000;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // long_write_timer

// ==== sim/flash_prog_checker.sv ====
`timescale 1ns/1ps
module flash_prog_checker #(
    parameter logic [18:0] ERASE_CYC = 19'd20,
    parameter logic [18:0] PROG_CYC = 19'd20
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic write_abort_pin,
    input wire logic cpu_stall,
    input flash_prog_pkg::arr_rd_t arr_rd,
    input flash_prog_pkg::arr_cmd_t arr_cmd
);
    import flash_prog_pkg::*;
    // ----------
    // Unlock tracking and long-write length
    // ----------
    logic key_r, key_nxt, armed_r, armed_nxt, ab_r, ab_nxt, tk;
    logic [19:0] cnt_r, cnt_nxt;
    assign tk = (avs_read | avs_write) & ~avs_waitrequest;
    always_comb begin
        key_nxt = key_r;
        armed_nxt = armed_r;
        if (tk) begin
            key_nxt = avs_write && avs_address == 5'h04 && avs_writedata[7:0] == 8'h55;
            armed_nxt = key_r && avs_write && avs_address == 5'h04 && avs_writedata[7:0] == 8'hAA;
        end
        cnt_nxt = cpu_stall ? cnt_r + 20'h1 : 20'h0;
        ab_nxt = cpu_stall & (ab_r | write_abort_pin);
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {key_r, armed_r, ab_r} <= 3'h0;
            cnt_r <= 20'h0;
        end else begin
            {key_r, armed_r, ab_r} <= {key_nxt, armed_nxt, ab_nxt};
            cnt_r <= cnt_nxt;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_stall_with_op: assert property ((arr_cmd.erase || arr_cmd.prog) |-> cpu_stall)
        else $error("array busy without core stall");
    a_bus_stalled: assert property (cpu_stall && (avs_read || avs_write) |-> avs_waitrequest)
        else $error("bus answered during long write");
    a_rd_follows: assert property (tk && avs_write && avs_address == 5'h14 && avs_writedata[0]
        |=> arr_rd.rd_en)
        else $error("table read did not reach array");
    a_rd_one_pulse: assert property (arr_rd.rd_en |=> !arr_rd.rd_en)
        else $error("array read longer than one byte fetch");
    a_tw_no_array: assert property (tk && avs_write && avs_address == 5'h14
        && avs_writedata[1:0] == 2'h2 |=> !(arr_rd.rd_en || arr_cmd.prog || arr_cmd.erase) [*2])
        else $error("table write touched the array");
    a_one_op_kind: assert property (!(arr_cmd.erase && arr_cmd.prog))
        else $error("erase and program together");
    a_row_steady: assert property (arr_cmd.erase && $past(arr_cmd.erase)
        |-> arr_cmd.row == $past(arr_cmd.row))
        else $error("erase row moved");
    a_start_unlocked: assert property ($rose(cpu_stall)
        |-> $past(armed_r && avs_write && avs_address == 5'h00))
        else $error("long write without unlock order");
    a_start_enabled: assert property ($rose(cpu_stall)
        |-> $past(avs_writedata[2] && avs_writedata[7] && !avs_writedata[6]))
        else $error("long write while disabled");
    a_kind_chosen: assert property ($rose(cpu_stall) |-> arr_cmd.erase == $past(avs_writedata[4])
        && arr_cmd.prog == !$past(avs_writedata[4]))
        else $error("wrong long write kind");
    a_timer_bound: assert property (cnt_r <= 20'(ERASE_CYC) + 20'h8)
        else $error("long write overran its timer");
    a_full_length: assert property ($fell(cpu_stall) |-> ab_r
        || cnt_r >= ($past(arr_cmd.erase) ? 20'(ERASE_CYC) : 20'(PROG_CYC)))
        else $error("long write ended early");
    c_done: cover property ($fell(cpu_stall) && !ab_r);
    c_erase: cover property ($rose(arr_cmd.erase));
    c_abort: cover property ($fell(cpu_stall) && ab_r);
endmodule // flash_prog_checker

bind flash_self_prog flash_prog_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
    flash_prog_checker_inst (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .write_abort_pin(write_abort_pin),
    .cpu_stall(cpu_stall), .arr_rd(arr_rd), .arr_cmd(arr_cmd));

// ==== sim/flash_array_model.sv ====
`timescale 1ns/1ps
module flash_array_model (
    input wire logic mclk,
    input flash_prog_pkg::arr_rd_t arr_rd,
    input flash_prog_pkg::arr_cmd_t arr_cmd,
    output logic [15:0] arr_rdata
);
    import flash_prog_pkg::*;
    // ----------
    // Array words, erased at power-up
    // ----------
    logic [15:0] mem [int];
    logic erase_q = 1'b0;
    logic prog_q = 1'b0;
    initial arr_rdata = 16'h5AA5;
    function automatic logic [15:0] word_at(int a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    // Commits at the start, so an aborted block still takes the new data
    always @(posedge mclk) begin
        int a;
        // Not held: toggles outside the answer cycle
        arr_rdata <= arr_rd.rd_en ? word_at(int'(arr_rd.word_addr)) : ~arr_rdata;
        if (arr_cmd.erase && !erase_q) begin
            for (int j = 0; j < 32; j++) mem[int'({arr_cmd.row[14:0], 5'(j)})] = 16'hFFFF;
        end
        if (arr_cmd.prog && !prog_q) begin
            for (int j = 0; j < 4; j++) begin
                a = int'({arr_cmd.block[17:0], 2'(j)});
                mem[a] = word_at(a) & arr_cmd.data[16*j +: 16];
            end
        end
        erase_q <= arr_cmd.erase;
        prog_q <= arr_cmd.prog;
    end
endmodule // flash_array_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
    import flash_prog_pkg::*;
    localparam logic [18:0] CYC = 19'd20;
    logic mclk, resetn, avs_read, avs_write, avs_waitrequest, write_abort_pin, cpu_stall;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] arr_rdata;
    arr_rd_t arr_rd;
    arr_cmd_t arr_cmd;
    int err_count, checks_done, ptr, base;
    logic [7:0] lat;
    logic [7:0] hold [8];
    logic [7:0] fm [int];
    int unsigned seed = 32'd56082;
    flash_self_prog #(.ERASE_CYC(CYC), .PROG_CYC(CYC)) flash_self_prog_inst (.mclk(mclk),
        .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .write_abort_pin(write_abort_pin), .cpu_stall(cpu_stall), .arr_rd(arr_rd),
        .arr_rdata(arr_rdata), .arr_cmd(arr_cmd));
    flash_array_model flash_array_model_inst (.mclk(mclk), .arr_rd(arr_rd), .arr_cmd(arr_cmd),
        .arr_rdata(arr_rdata));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ----------
    // Helpers and bus master
    // ----------
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int step(int p, int d);
        return (p & 32'h200000) | ((p + d) & 32'h1FFFFF);
    endfunction
    function automatic logic [7:0] fb(int p);
        return fm.exists(p) ? fm[p] : 8'hFF;
    endfunction
    task end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 400);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            end_of_test();
        end
        @(posedge mclk);
    endtask
    task automatic tcmd(input int op, input int m);
        bus(1'b1, 5'h14, 32'(op | (m << 2)));
        if (m == 3) ptr = step(ptr, 1);
        if (op == 1) begin
            bus(1'b0, 5'h08, 32'h0);
            chk("table latch", 32'(fb(ptr)), rd);
        end else hold[ptr & 7] = lat;
        if (m == 1) ptr = step(ptr, 1);
        if (m == 2) ptr = step(ptr, -1);
    endtask
    task automatic lw(input logic [31:0] ctl, input int keys, input logic abort);
        int n = 0;
        logic go;
        go = keys == 2 && ctl[2] && ctl[7] && !ctl[6];
        if (keys > 0) bus(1'b1, 5'h04, 32'h55);
        if (keys == 1) bus(1'b0, 5'h10, 32'h0);
        if (keys > 0) bus(1'b1, 5'h04, 32'hAA);
        bus(1'b1, 5'h00, ctl);
        chk("stall", 32'(go), 32'(cpu_stall));
        if (go && !abort) bus(1'b0, 5'h0C, 32'h0);
        while (cpu_stall !== 1'b0 && n < 400) begin
            @(posedge mclk);
            n++;
            if (abort && n == 4) write_abort_pin <= 1'b1;
        end
        if (n >= 400) begin
            err_count++;
            end_of_test();
        end
        if (go) begin
            if (ctl[4]) for (int i = 0; i < 64; i++) fm.delete((ptr & ~63) + i);
            else for (int i = 0; i < 8; i++) fm[(ptr & ~7) + i] = fb((ptr & ~7) + i) & hold[i];
            foreach (hold[i]) hold[i] = 8'hFF;
        end
        write_abort_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        bus(1'b0, 5'h00, 32'h0);
        if (go && !abort) chk("control", ctl & 32'h84, rd);
        else chk("write error", 32'h08, rd & 32'h08);
        bus(1'b0, 5'h10, 32'h0);
        chk("done flag", 32'(go && !abort) << 4, rd);
        bus(1'b1, 5'h10, 32'h0);
    endtask
    // ----------
    // Main sequence
    // ----------
    initial begin
        {resetn, avs_read, avs_write, write_abort_pin} = 4'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        {err_count, checks_done, ptr} = 96'h0;
        lat = 8'h00;
        foreach (hold[i]) hold[i] = 8'hFF;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 32; a += 4) begin
            bus(1'b0, 5'(a), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        lw(32'h86, 0, 1'b0);
        lw(32'h86, 1, 1'b0);
        lw(32'h82, 2, 1'b0);
        lw(32'hC6, 2, 1'b0);
        base = int'(xs() & 32'h1FFFC0) | 32'h40;
        // Pass 1 aborts; pass 2 reuses the cleared holding registers
        for (int pass = 0; pass < 3; pass++) begin
            ptr = step(base, -1);
            bus(1'b1, 5'h0C, 32'(ptr));
            for (int i = 0; i < 8 && pass < 2; i++) begin
                lat = (i == 3) ? 8'hFF : 8'(xs());
                bus(1'b1, 5'h08, 32'(lat));
                tcmd(2, 3);
            end
            lw(32'h86, 2, pass == 1);
            ptr = base;
            bus(1'b1, 5'h0C, 32'(ptr));
            for (int i = 0; i < 12; i++) tcmd(1, i < 8 ? 1 : i % 4);
            bus(1'b0, 5'h0C, 32'h0);
            chk("pointer", 32'(ptr), rd);
        end
        ptr = base + int'(xs() & 32'h3F);
        bus(1'b1, 5'h0C, 32'(ptr));
        lw(32'h96, 2, 1'b0);
        ptr = base;
        bus(1'b1, 5'h0C, 32'(ptr));
        for (int i = 0; i < 8; i++) tcmd(1, 1);
        end_of_test();
    end
endmodule // tb
